// >>> pkg/fault_policy_pkg.sv
package fault_policy_pkg;
   // register offsets on the serial register port
   localparam logic [7:0] MODE_OFS  = 8'h10;
   localparam logic [7:0] SFE_OFS   = 8'h12;
   localparam logic [7:0] RETRY_OFS = 8'h16;
   localparam logic [7:0] CLR_OFS   = 8'h17;

   // reset values and writable bit masks (bit 15 handled apart)
   localparam logic [15:0] MODE_RST   = 16'h0015;
   localparam logic [15:0] SFE_RST    = 16'h0553;
   localparam logic [15:0] RETRY_RST  = 16'h0003;
   localparam logic [15:0] MODE_WMASK = 16'h1FFF;
   localparam logic [15:0] SFE_WMASK  = 16'h07D3;
   localparam logic [15:0] RETRY_WMASK = 16'h000F;

   // field positions
   localparam int PARITY_BIT   = 15;
   localparam int SUP_WARN_LSB = 11;
   localparam int OV_LSB       = 9;
   localparam int SER_BIT      = 7;
   localparam int OC_LSB       = 4;
   localparam int UV_LSB       = 2;
   localparam int OT_LSB       = 0;
   localparam int NRDY_EN_BIT  = 10;
   localparam int FET_EN_BIT   = 9;
   localparam int SUP_EN_BIT   = 7;
   localparam int QUICK_LSB    = 0;
   localparam int LONG_LSB     = 2;
   localparam int CLR_BIT      = 0;

   // fault channel indices
   localparam int CH_SUP_WARN = 0;
   localparam int CH_OV       = 1;
   localparam int CH_SER      = 2;
   localparam int CH_OC       = 3;
   localparam int CH_UV       = 4;
   localparam int CH_OT       = 5;
   localparam int CH_NRDY     = 6;
   localparam int CH_FET_HOT  = 7;
   localparam int NUM_CH      = 8;

   // timing: one retry tick is 0.5 ms at the 250 MHz clock
   localparam int CLK_MHZ     = 250;
   localparam int TICK_US     = 500;
   localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
   localparam int QUICK_US [4] = '{500, 1000, 2000, 5000};
   localparam int LONG_MS  [4] = '{500, 1000, 2000, 5000};
   localparam int RETRY_CNT_W = 14;

   // per channel state
   typedef enum logic [1:0] {
      CH_IDLE  = 2'b01,
      CH_HELD  = 2'b10
   } ch_state_t;
endpackage

// >>> pkg/retry_tick_if.sv
`timescale 1ns/1ps
interface retry_tick_if;
   logic tick;   // one-cycle 0.5 ms enable
   modport src (output tick);
   modport dst (input tick);
endinterface

// >>> rtl/retry_tick_gen.sv
`timescale 1ns/1ps
module retry_tick_gen #(
   parameter int TICK_CYCLES = fault_policy_pkg::TICK_CYCLES
) (
   input  wire logic  i_sys_clk,   // device clock
   input  wire logic  i_rst,       // async reset, high
   retry_tick_if.src  tick_out     // tick enable
);
   logic [31:0] div_reg;
   logic        tick_reg;

   // free running divider, one-cycle pulse each TICK_CYCLES
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         div_reg  <= 32'h0;
         tick_reg <= 1'b0;
      end else if (div_reg == 32'(TICK_CYCLES - 1)) begin
         div_reg  <= 32'h0;
         tick_reg <= 1'b1;
      end else begin
         div_reg  <= div_reg + 32'h1;
         tick_reg <= 1'b0;
      end
   end

   assign tick_out.tick = tick_reg;
endmodule

// >>> rtl/fault_response_policy.sv
// Summary of operation
// - with parity checking on, bit 15 of each control register is parity
// - supply warn mode: 0 slow retry, 1 fast retry, 2 report only, 3 off
// - overvoltage mode: 0 Hi-Z slow retry, 1 Hi-Z fast retry
// - serial fault bit clear reports and latches only; set disables it
// - overcurrent mode resets to 1: 0 slow, 1 fast, 3 report only
// - overcurrent mode 2 holds Hi-Z until the clear command
// - undervoltage mode resets to 1: 0 slow retry, 1 fast retry
// - overtemperature mode: 0 Hi-Z slow retry, 1 Hi-Z fast retry
// - not-ready enable, reset 1, lets the not-ready fault be raised
// - FET hot warning enable, reset 0, gates that fault
// - supply low warning enable, reset 0, gates that fault
// - fast retry time selectable 0.5, 1, 2 or 5 ms
// - slow retry time selectable 0.5, 1, 2 or 5 s
// - writing 1 to the clear bit clears latches; bit self-returns to 0
`timescale 1ns/1ps
module fault_response_policy #(
   parameter int TICK_CYCLES = fault_policy_pkg::TICK_CYCLES
) (
   input  wire logic        i_sys_clk,            // device clock
   input  wire logic        i_rst,                // async reset, high
   input  wire logic        i_parity_check_enable, // parity mode on
   input  wire logic        i_reg_wr,             // register write strobe
   input  wire logic        i_reg_rd,             // register read strobe
   input  wire logic [7:0]  i_reg_addr,           // register offset
   input  wire logic [15:0] i_reg_wdata,          // write data
   input  wire logic [7:0]  i_fault_detect,       // raw fault conditions
   output logic      [15:0] o_reg_rdata,          // read data, registered
   output logic             o_reg_rvalid,         // read data valid
   output logic      [7:0]  o_fault_latched,      // latched status
   output logic             o_predriver_hiz,      // pre-driver tri-state
   output logic             o_fault_indicator_n   // fault pin, low active
);
   localparam int NCH = fault_policy_pkg::NUM_CH;
   localparam int CW  = fault_policy_pkg::RETRY_CNT_W;

   generate
      if (TICK_CYCLES < 2) begin : g_bad_tick
         $error("TICK_CYCLES must be at least 2");
      end
   endgenerate

   logic [15:0] mode_reg;
   logic [15:0] sfe_reg;
   logic [15:0] retry_reg;
   logic        clr_reg;
   logic [NCH-1:0] latched_reg;
   logic [NCH-1:0] hiz_reg;
   logic [NCH-1:0] ch_report;
   logic [NCH-1:0] ch_hiz;
   logic [NCH-1:0] ch_auto;
   logic [NCH-1:0] ch_fast;
   logic [15:0] wr_par;
   logic [15:0] rd_keep;
   logic [CW-1:0] quick_target;
   logic [CW-1:0] long_target;

   retry_tick_if tick_bus ();

   retry_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .tick_out  (tick_bus)
   );

   // retry length in 0.5 ms ticks for a two-bit code
   function automatic logic [CW-1:0] quick_ticks(input logic [1:0] code);
      quick_ticks = CW'(fault_policy_pkg::QUICK_US[code]
                        / fault_policy_pkg::TICK_US);
   endfunction

   function automatic logic [CW-1:0] long_ticks(input logic [1:0] code);
      long_ticks = CW'((fault_policy_pkg::LONG_MS[code] * 1000)
                       / fault_policy_pkg::TICK_US);
   endfunction

   // parity bit kept only while parity checking is on
   assign wr_par = i_parity_check_enable ?
                   (i_reg_wdata & 16'h8000) : 16'h0000;

   // bit 15 reads as zero while parity checking is off
   assign rd_keep = i_parity_check_enable ? 16'hFFFF : 16'h7FFF;

   // control register writes
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         mode_reg  <= fault_policy_pkg::MODE_RST;
         sfe_reg   <= fault_policy_pkg::SFE_RST;
         retry_reg <= fault_policy_pkg::RETRY_RST;
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            fault_policy_pkg::MODE_OFS: begin
               mode_reg <= (i_reg_wdata & fault_policy_pkg::MODE_WMASK)
                           | wr_par;
            end
            fault_policy_pkg::SFE_OFS: begin
               sfe_reg <= (i_reg_wdata & fault_policy_pkg::SFE_WMASK)
                          | wr_par;
            end
            fault_policy_pkg::RETRY_OFS: begin
               retry_reg <= (i_reg_wdata & fault_policy_pkg::RETRY_WMASK)
                            | wr_par;
            end
            default: begin
               mode_reg <= mode_reg;
            end
         endcase
      end
   end

   // clear command: one-cycle pulse, bit never stores
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         clr_reg <= 1'b0;
      end else begin
         clr_reg <= i_reg_wr && (i_reg_addr == fault_policy_pkg::CLR_OFS)
                    && i_reg_wdata[fault_policy_pkg::CLR_BIT];
      end
   end

   // register read port, one cycle latency, unmapped reads zero
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_reg_rdata  <= 16'h0000;
         o_reg_rvalid <= 1'b0;
      end else begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            case (i_reg_addr)
               fault_policy_pkg::MODE_OFS:  o_reg_rdata <= mode_reg & rd_keep;
               fault_policy_pkg::SFE_OFS:   o_reg_rdata <= sfe_reg & rd_keep;
               fault_policy_pkg::RETRY_OFS: o_reg_rdata <= retry_reg & rd_keep;
               default:                     o_reg_rdata <= 16'h0000;
            endcase
         end
      end
   end

   // retry lengths from the retry time register
   always_comb begin
      quick_target = quick_ticks(
         retry_reg[fault_policy_pkg::QUICK_LSB +: 2]);
      long_target = long_ticks(
         retry_reg[fault_policy_pkg::LONG_LSB +: 2]);
   end

   // decode each class into report, tri-state, auto retry and speed
   always_comb begin
      logic [1:0] m2;
      logic [2:0] m3;
      m2 = 2'b00;
      m3 = 3'b000;
      ch_report = '0;
      ch_hiz    = '0;
      ch_auto   = '0;
      ch_fast   = '0;
      // supply low warning
      m2 = mode_reg[fault_policy_pkg::SUP_WARN_LSB +: 2];
      ch_report[fault_policy_pkg::CH_SUP_WARN] =
         sfe_reg[fault_policy_pkg::SUP_EN_BIT] && (m2 != 2'h3);
      ch_hiz[fault_policy_pkg::CH_SUP_WARN]  = (m2 < 2'h2);
      ch_auto[fault_policy_pkg::CH_SUP_WARN] = (m2 < 2'h2);
      ch_fast[fault_policy_pkg::CH_SUP_WARN] = (m2 == 2'h1);
      // overvoltage, reserved codes act as code 0
      m2 = mode_reg[fault_policy_pkg::OV_LSB +: 2];
      ch_report[fault_policy_pkg::CH_OV] = 1'b1;
      ch_hiz[fault_policy_pkg::CH_OV]    = 1'b1;
      ch_auto[fault_policy_pkg::CH_OV]   = 1'b1;
      ch_fast[fault_policy_pkg::CH_OV]   = (m2 == 2'h1);
      // serial interface fault: report only or disabled
      ch_report[fault_policy_pkg::CH_SER] =
         !mode_reg[fault_policy_pkg::SER_BIT];
      // overcurrent, reserved codes act as code 0
      m3 = mode_reg[fault_policy_pkg::OC_LSB +: 3];
      ch_report[fault_policy_pkg::CH_OC] = 1'b1;
      ch_hiz[fault_policy_pkg::CH_OC]    = (m3 != 3'h3);
      ch_auto[fault_policy_pkg::CH_OC]   = (m3 < 3'h2) || (m3 > 3'h3);
      ch_fast[fault_policy_pkg::CH_OC]   = (m3 == 3'h1);
      // undervoltage
      m2 = mode_reg[fault_policy_pkg::UV_LSB +: 2];
      ch_report[fault_policy_pkg::CH_UV] = 1'b1;
      ch_hiz[fault_policy_pkg::CH_UV]    = 1'b1;
      ch_auto[fault_policy_pkg::CH_UV]   = 1'b1;
      ch_fast[fault_policy_pkg::CH_UV]   = (m2 == 2'h1);
      // overtemperature
      m2 = mode_reg[fault_policy_pkg::OT_LSB +: 2];
      ch_report[fault_policy_pkg::CH_OT] = 1'b1;
      ch_hiz[fault_policy_pkg::CH_OT]    = 1'b1;
      ch_auto[fault_policy_pkg::CH_OT]   = 1'b1;
      ch_fast[fault_policy_pkg::CH_OT]   = (m2 == 2'h1);
      // enable-only faults, report and latch
      ch_report[fault_policy_pkg::CH_NRDY] =
         sfe_reg[fault_policy_pkg::NRDY_EN_BIT];
      ch_report[fault_policy_pkg::CH_FET_HOT] =
         sfe_reg[fault_policy_pkg::FET_EN_BIT];
   end

   // per class latch, tri-state hold and retry timer
   generate
      for (genvar c = 0; c < NCH; c++) begin : g_ch
         logic [CW-1:0] cnt_reg;
         logic [CW-1:0] target;
         logic          raise;
         logic          expire;

         assign raise  = i_fault_detect[c] && ch_report[c];
         assign target = ch_fast[c] ? quick_target : long_target;
         assign expire = ch_auto[c] && latched_reg[c] && tick_bus.tick
                         && (cnt_reg + CW'(1) >= target);

         // retry timer counts ticks while latched in an auto retry class, restarts on expiry
         always_ff @(posedge i_sys_clk or posedge i_rst) begin
            if (i_rst) begin
               cnt_reg <= '0;
            end else if (!latched_reg[c] || !ch_auto[c] || expire) begin
               cnt_reg <= '0;
            end else if (tick_bus.tick) begin
               cnt_reg <= cnt_reg + CW'(1);
            end
         end

         // latch: a new fault wins over retry expiry and clear
         always_ff @(posedge i_sys_clk or posedge i_rst) begin
            if (i_rst) begin
               latched_reg[c] <= 1'b0;
               hiz_reg[c]     <= 1'b0;
            end else if (raise) begin
               latched_reg[c] <= 1'b1;
               hiz_reg[c]     <= ch_hiz[c];
            end else if (clr_reg || expire || !ch_report[c]) begin
               latched_reg[c] <= 1'b0;
               hiz_reg[c]     <= 1'b0;
            end
         end
      end
   endgenerate

   // outputs from flip-flops
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_fault_latched     <= '0;
         o_predriver_hiz     <= 1'b0;
         o_fault_indicator_n <= 1'b1;
      end else begin
         o_fault_latched     <= latched_reg;
         o_predriver_hiz     <= |hiz_reg;
         o_fault_indicator_n <= ~(|latched_reg);
      end
   end
endmodule

// >>> test/fault_policy_sva.sv
`timescale 1ns/1ps
module fault_policy_sva (
   input wire logic        i_sys_clk,             // clock
   input wire logic        i_rst,                 // reset
   input wire logic        i_parity_check_enable, // parity mode
   input wire logic        i_reg_wr,              // write strobe
   input wire logic        i_reg_rd,              // read strobe
   input wire logic [7:0]  i_reg_addr,            // offset
   input wire logic [15:0] i_reg_wdata,           // write data
   input wire logic [7:0]  i_fault_detect,        // raw faults
   input wire logic [15:0] o_reg_rdata,           // read data
   input wire logic        o_reg_rvalid,          // read valid
   input wire logic [7:0]  o_fault_latched,       // latched status
   input wire logic        o_predriver_hiz,       // tri-state
   input wire logic        o_fault_indicator_n    // fault pin
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // read request at one offset
   sequence rd_at(logic [7:0] a);
      i_reg_rd && i_reg_addr == a;
   endsequence
   // clear command with no fault present, then two quiet cycles
   sequence clr_issued;
      i_reg_wr && i_reg_addr == fault_policy_pkg::CLR_OFS && i_reg_wdata[0]
         && i_fault_detect == 8'h00;
   endsequence
   sequence quiet_2;
      (i_fault_detect == 8'h00) [*2];
   endsequence
   parity_off_a: assert property (rd_at(fault_policy_pkg::MODE_OFS) ##0
      !i_parity_check_enable |=> o_reg_rdata[15] == 1'b0)
      else $error("parity bit seen while parity off");
   mode_resv_a: assert property (rd_at(fault_policy_pkg::MODE_OFS)
      |=> o_reg_rdata[14:13] == 2'b00) else $error("reserved mode bits set");
   sfe_resv_a: assert property (rd_at(fault_policy_pkg::SFE_OFS)
      |=> (o_reg_rdata & 16'h782C) == 16'h0000)
      else $error("read-only enable bits set");
   clear_reads_a: assert property (rd_at(fault_policy_pkg::CLR_OFS)
      |=> o_reg_rdata == 16'h0000) else $error("clear bit reads nonzero");
   clear_effect_a: assert property (clr_issued ##1 quiet_2
      |=> o_fault_latched == 8'h00) else $error("clear left latches");
   pin_tracks_a: assert property (
      o_fault_indicator_n == (o_fault_latched == 8'h00))
      else $error("fault pin disagrees with latches");
   hiz_cause_a: assert property (o_predriver_hiz
      |-> o_fault_latched != 8'h00) else $error("tri-state without fault");
   oc_cause_a: assert property ($rose(o_fault_latched[3])
      |-> $past(i_fault_detect[3], 2)) else $error("overcurrent latch early");
   rd_answer_a: assert property (i_reg_rd |=> o_reg_rvalid)
      else $error("read not answered");
endmodule

// >>> test/host_model.sv
`timescale 1ns/1ps
module host_model (
   input  wire logic        i_sys_clk, // device clock
   input  wire logic        i_rvalid,  // read valid
   input  wire logic [15:0] i_rdata,   // read data
   output logic             o_wr,      // write strobe
   output logic             o_rd,      // read strobe
   output logic      [7:0]  o_addr,    // offset
   output logic      [15:0] o_wdata    // write data
);
   // idle port at time zero
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 16'h0000;
   end
   // one write; released lines show the inverse, not the old value
   task automatic wr(logic [7:0] a, logic [15:0] d);
      @(posedge i_sys_clk) #1;
      o_addr = a;
      o_wdata = d;
      o_wr = 1'b1;
      @(posedge i_sys_clk) #1;
      o_wr = 1'b0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask
   // one read; data taken only if the answer is valid
   task automatic rd(logic [7:0] a, output logic [15:0] d);
      @(posedge i_sys_clk) #1;
      o_addr = a;
      o_rd = 1'b1;
      @(posedge i_sys_clk) #1;
      o_rd = 1'b0;
      o_addr = ~a;
      d = i_rvalid ? i_rdata : 16'hXXXX;
   endtask
   // clear command
   task automatic clear();
      wr(fault_policy_pkg::CLR_OFS, 16'h0001);
   endtask
endmodule

// >>> test/fault_response_policy_test.sv
`timescale 1ns/1ps
module fault_response_policy_test;
   logic        i_sys_clk, i_rst, i_parity_check_enable, i_reg_wr, i_reg_rd;
   logic [7:0]  i_reg_addr, i_fault_detect, o_fault_latched;
   logic [15:0] i_reg_wdata, o_reg_rdata, rv;
   logic        o_reg_rvalid, o_predriver_hiz, o_fault_indicator_n;
   int          error_cnt = 0;
   int          n_tests = 0;
   // retry tick length in clocks used by this bench
   localparam int TK = 4;
   // fast retry lengths in 0.5 ms ticks for codes 0 to 3
   localparam int QN [4] = '{1, 2, 4, 10};
   // mode word, enable word, channel, flags latch/hiz/retry
   localparam logic [39:0] CASES [21] = '{
      40'h0000_05D3_0_C, 40'h0800_05D3_0_E, 40'h1000_05D3_0_8,
      40'h1800_05D3_0_0, 40'h0000_0553_0_0, 40'h0000_0553_1_C,
      40'h0200_0553_1_E, 40'h0000_0553_2_8, 40'h0080_0553_2_0,
      40'h0000_0553_3_C, 40'h0010_0553_3_E, 40'h0020_0553_3_C,
      40'h0030_0553_3_8, 40'h0000_0553_4_C, 40'h0004_0553_4_E,
      40'h0000_0553_5_C, 40'h0001_0553_5_E, 40'h0000_0553_6_8,
      40'h0000_0153_6_0, 40'h0000_0553_7_0, 40'h0000_0753_7_8};
   localparam logic [7:0]  OFS [5] = '{8'h10, 8'h12, 8'h16, 8'h17, 8'h20};
   localparam logic [15:0] RSTV [5] = '{16'h0015, 16'h0553, 16'h0003,
      16'h0000, 16'h0000};
   fault_response_policy #(.TICK_CYCLES(TK)) fault_response_policy_i (
      .i_sys_clk, .i_rst, .i_parity_check_enable, .i_reg_wr, .i_reg_rd,
      .i_reg_addr, .i_reg_wdata, .i_fault_detect, .o_reg_rdata,
      .o_reg_rvalid, .o_fault_latched, .o_predriver_hiz,
      .o_fault_indicator_n);
   host_model host_model_i (.i_sys_clk, .i_rvalid(o_reg_rvalid),
      .i_rdata(o_reg_rdata), .o_wr(i_reg_wr), .o_rd(i_reg_rd),
      .o_addr(i_reg_addr), .o_wdata(i_reg_wdata));
   // clock
   initial begin
      i_sys_clk = 1'b0;
      forever #2 i_sys_clk = ~i_sys_clk;
   end
   task automatic chk16(string n, logic [15:0] e, logic [15:0] s);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %s exp %h got %h", n, e, s);
      end
   endtask
   task automatic chk1(string n, logic e, logic s);
      n_tests++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %s exp %b got %b", n, e, s);
      end
   endtask
   // expected read-back of a written word
   function automatic logic [15:0] exp_reg(logic [7:0] a, logic [15:0] d,
      logic p);
      logic [15:0] m;
      m = (a == 8'h10) ? 16'h1FFF : (a == 8'h12) ? 16'h07D3 : 16'h000F;
      return d & (m | {p, 15'h0000});
   endfunction
   // one fault pulse under given modes, then retry window and clear
   task automatic run_case(logic [39:0] e);
      int c;
      c = int'(e[6:4]);
      host_model_i.wr(8'h10, e[39:24]);
      host_model_i.wr(8'h12, e[23:8]);
      @(posedge i_sys_clk) #1 i_fault_detect[c] = 1'b1;
      @(posedge i_sys_clk) #1 i_fault_detect = 8'h00;
      repeat (2) @(posedge i_sys_clk);
      #1 chk1("latched", e[3], o_fault_latched[c]);
      chk1("hiz", e[2], o_predriver_hiz);
      chk1("pin", !e[3], o_fault_indicator_n);
      repeat (50) @(posedge i_sys_clk);
      #1 chk1("retried", e[3] & !e[1], o_fault_latched[c]);
      chk1("hiz held", e[2] & !e[1], o_predriver_hiz);
      host_model_i.clear();
      repeat (4) @(posedge i_sys_clk);
      #1 chk1("cleared", 1'b1, o_fault_latched === 8'h00);
      chk1("pin released", 1'b1, o_fault_indicator_n);
   endtask
   // overcurrent pulse, latch must last n ticks less one and end by n
   task automatic run_retry(logic [15:0] m, logic [15:0] r, int n);
      host_model_i.wr(8'h16, r);
      host_model_i.wr(8'h10, m);
      @(posedge i_sys_clk) #1 i_fault_detect[3] = 1'b1;
      @(posedge i_sys_clk) #1 i_fault_detect = 8'h00;
      repeat (TK * n - TK + 1) @(posedge i_sys_clk);
      #1 chk1("retry early", 1'b1, o_fault_latched[3]);
      repeat (TK) @(posedge i_sys_clk);
      #1 chk1("retry late", 1'b0, o_fault_latched[3]);
   endtask
   task automatic complete_run();
      if (error_cnt == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // watchdog
   initial begin
      repeat (20000) @(posedge i_sys_clk);
      error_cnt++;
      complete_run();
   end
   // main sequence
   initial begin
      logic [7:0]  a;
      logic [15:0] d;
      i_rst = 1'b1;
      i_parity_check_enable = 1'b0;
      i_fault_detect = 8'h00;
      void'($urandom(32'hBE593567));
      repeat (16) @(posedge i_sys_clk);
      #1 i_rst = 1'b0;
      foreach (OFS[k]) begin
         host_model_i.rd(OFS[k], rv);
         chk16("reset value", RSTV[k], rv);
      end
      foreach (CASES[k]) begin
         run_case(CASES[k]);
      end
      foreach (QN[q]) begin
         run_retry(16'h0010, 16'(q), QN[q]);
      end
      // reserved overcurrent code acts as slow, slow code 0 is 1000 ticks
      run_retry(16'h0040, 16'h0003, 1000);
      for (int k = 0; k < 10; k++) begin
         a = OFS[$urandom_range(2)];
         d = 16'($urandom);
         @(posedge i_sys_clk) #1 i_parity_check_enable = 1'($urandom);
         host_model_i.wr(a, d);
         host_model_i.rd(a, rv);
         chk16("write back", exp_reg(a, d, i_parity_check_enable), rv);
         @(posedge i_sys_clk) #1 i_parity_check_enable = 1'b0;
         host_model_i.rd(a, rv);
         chk16("parity off", exp_reg(a, d, 1'b0), rv);
      end
      host_model_i.wr(8'h20, 16'hFFFF);
      host_model_i.rd(8'h20, rv);
      chk16("unmapped", 16'h0000, rv);
      complete_run();
   end
endmodule
bind fault_response_policy fault_policy_sva fault_policy_sva_i (
   .i_sys_clk, .i_rst, .i_parity_check_enable, .i_reg_wr, .i_reg_rd,
   .i_reg_addr, .i_reg_wdata, .i_fault_detect, .o_reg_rdata, .o_reg_rvalid,
   .o_fault_latched, .o_predriver_hiz, .o_fault_indicator_n);
